//--- verilog/sdc_pkg.sv
package sdc_pkg;
   // ************************************************************
   // widths
   // ************************************************************
   localparam int ADDR_W = 12;          // row / column / op-code lines
   localparam int BANK_W = 2;           // bank-select lines
   localparam int NBANK = 4;            // quad bank
   localparam int DQ_W = 16;            // data lines
   localparam int DM_W = 2;             // one mask per byte
   localparam int COL_W = 9;            // column bits used
   localparam int AP_BIT = 10;          // auto close select bit
   localparam int FIFO_DEPTH = 8;       // read data buffer depth
   localparam int MEM_WORDS = 256;      // small model array per bank
   localparam int MEM_AW = 8;           // index into the model array
   localparam int RFC_W = 12;           // refresh row counter width

   // ************************************************************
   // reset values and burst / latency counts
   // ************************************************************
   localparam logic [11:0] MODE_RST = 12'h0_000;   // mode register after reset
   localparam logic [3:0] BURST_LEN = 4'h0_4;      // fixed burst length
   localparam logic [3:0] BURST_ONE = 4'h0_1;      // last beat count
   localparam int MASK_DLY = 2;                    // read mask delay in clocks

   // ************************************************************
   // decoded commands and bank states
   // ************************************************************
   typedef enum logic [3:0] {
      SDC_CMD_NOP = 4'h0, SDC_CMD_ACT = 4'h1, SDC_CMD_RD = 4'h2, SDC_CMD_WR = 4'h3,
      SDC_CMD_BST = 4'h4, SDC_CMD_PRE = 4'h5, SDC_CMD_REF = 4'h6, SDC_CMD_MODE = 4'h7,
      SDC_CMD_SREF = 4'h8, SDC_CMD_DEEP = 4'h9
   } sdc_cmd_e;

   typedef enum logic [1:0] {
      SDC_IDLE = 2'b00, SDC_OPEN = 2'b01, SDC_BURST = 2'b11
   } sdc_bank_e;

   typedef enum logic [1:0] {
      SDC_PWR_RUN = 2'b00, SDC_PWR_SELF = 2'b01, SDC_PWR_DEEP = 2'b11
   } sdc_pwr_e;

   // command pins as they arrive
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [BANK_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic [DM_W-1:0] dqm;
      logic [DQ_W-1:0] dq;
   } sdc_pins_s;

   // read word plus its byte enables
   typedef struct packed {
      logic [DM_W-1:0] oe;
      logic [DQ_W-1:0] data;
   } sdc_rd_s;
endpackage

//--- verilog/sdc_fifo.sv
`timescale 1ns/1ps
module sdc_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];       // storage
   logic [PW:0] wr_r;                   // write pointer with wrap bit
   logic [PW:0] rd_r;                   // read pointer with wrap bit
   logic push;
   logic pop;

   // honest full and empty from pointer compare
   assign in_ready = !((wr_r[PW] != rd_r[PW]) && (wr_r[PW-1:0] == rd_r[PW-1:0]));
   assign out_valid = (wr_r != rd_r);
   assign out_data = mem[rd_r[PW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage write, no reset needed on data
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_r[PW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule

//--- verilog/sdc_core.sv
`timescale 1ns/1ps
// How it works
// - all pins sampled on rising clock only
// - chip select high: no new command
// - all strobes high: no operation
// - decode strobes into seven commands
// - terminate code with enable low: deep sleep
// - refresh code with enable low: self refresh
// - refresh uses internal row counter only
// - bit ten selects auto close per access
// - precharge bit ten high closes all banks
// - mode load stores address lines as op-code
// - activate opens addressed row in bank
// - access takes column and bank, bursts
// - auto close shuts row after burst
// - read mask floats data two clocks later
// - write mask blocks that byte now
// - terminate cuts most recent burst
// - self refresh ignores all but enable
// - deep sleep needs idle banks, enable exits
// - new column accepted every clock
module sdc_core
   import sdc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DM_W-1:0] dqm,
   input wire logic [DQ_W-1:0] dq_in,
   output logic [DQ_W-1:0] dq_out,
   output logic [DM_W-1:0] dq_oe,
   output logic [ADDR_W-1:0] mode_reg,
   output logic [NBANK-1:0] bank_open,
   output logic self_refresh_on,
   output logic deepest_sleep_mode,
   output logic [RFC_W-1:0] refresh_row
);
   // ************************************************************
   // input synchronisers
   // ************************************************************
   sdc_pins_s pin_s1_r;                 // first stage, read only by second
   sdc_pins_s pin_r;                    // sampled pins used by all logic

   // two flops before any logic, rising edge only
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
         pin_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1, default: '0};
      end else begin
         pin_s1_r <= '{cs_n, ras_n, cas_n, we_n, cke, ba, addr, dqm, dq_in};
         pin_r <= pin_s1_r;
      end
   end

   // ************************************************************
   // command decode
   // ************************************************************
   sdc_cmd_e cmd;                       // decoded command this cycle

   // strobe table, qualified by chip select; enable splits two codes
   always_comb begin
      cmd = SDC_CMD_NOP;
      if (pin_r.cs_n) begin
         cmd = SDC_CMD_NOP;
      end else begin
         case ({pin_r.ras_n, pin_r.cas_n, pin_r.we_n})
            3'b111: cmd = SDC_CMD_NOP;
            3'b011: cmd = SDC_CMD_ACT;
            3'b101: cmd = SDC_CMD_RD;
            3'b100: cmd = SDC_CMD_WR;
            3'b110: cmd = pin_r.cke ? SDC_CMD_BST : SDC_CMD_DEEP;
            3'b010: cmd = SDC_CMD_PRE;
            3'b001: cmd = pin_r.cke ? SDC_CMD_REF : SDC_CMD_SREF;
            3'b000: cmd = SDC_CMD_MODE;
            default: cmd = SDC_CMD_NOP;
         endcase
      end
   end

   // ************************************************************
   // power state
   // ************************************************************
   sdc_pwr_e pwr_r;                     // run, self refresh, deep sleep
   logic all_idle;                      // no bank holds an open row
   logic run;                           // commands may execute

   assign run = (pwr_r == SDC_PWR_RUN);

   // power entry and exit; only enable is watched while asleep
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_r <= SDC_PWR_RUN;
      end else begin
         case (pwr_r)
            SDC_PWR_RUN: begin
               if (cmd == SDC_CMD_SREF && all_idle) begin
                  pwr_r <= SDC_PWR_SELF;
               end else if (cmd == SDC_CMD_DEEP && all_idle) begin
                  pwr_r <= SDC_PWR_DEEP;
               end
            end
            SDC_PWR_SELF: begin
               if (pin_r.cke) begin
                  pwr_r <= SDC_PWR_RUN;
               end
            end
            SDC_PWR_DEEP: begin
               if (pin_r.cke) begin
                  pwr_r <= SDC_PWR_RUN;
               end
            end
            default: pwr_r <= SDC_PWR_RUN;
         endcase
      end
   end

   // ************************************************************
   // refresh counter and mode register
   // ************************************************************
   logic [RFC_W-1:0] rfc_r;             // internal refresh row
   logic [ADDR_W-1:0] mode_r;           // stored op-code

   // refresh ignores address pins, counts internally
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rfc_r <= '0;
      end else if (run && cmd == SDC_CMD_REF && all_idle) begin
         rfc_r <= rfc_r + 1'b1;
      end
   end

   // mode load takes the whole address bus
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= MODE_RST;
      end else if (run && cmd == SDC_CMD_MODE && all_idle) begin
         mode_r <= pin_r.addr;
      end
   end

   // ************************************************************
   // per-bank row state
   // ************************************************************
   sdc_bank_e bank_st_r [NBANK];        // per-bank state
   logic [ADDR_W-1:0] row_r [NBANK];    // open row per bank
   logic [NBANK-1:0] ap_r;              // auto close pending per bank
   logic [NBANK-1:0] open_vec;          // any row open
   logic [NBANK-1:0] burst_end;         // bank's burst finishing now
   logic rw_cmd;                        // read or write this cycle
   logic [BANK_W-1:0] cur_bank_r;       // bank of most recent burst
   logic [3:0] beat_r;                  // beats left in burst
   logic is_wr_r;                       // burst direction
   logic [COL_W-1:0] col_r;             // current burst column

   assign all_idle = (open_vec == '0);
   assign rw_cmd = run && (cmd == SDC_CMD_RD || cmd == SDC_CMD_WR);

   generate
      for (genvar b = 0; b < NBANK; b++) begin : g_bank
         logic sel;                     // command addresses this bank
         assign sel = (pin_r.ba == BANK_W'(b));
         assign open_vec[b] = (bank_st_r[b] != SDC_IDLE);
         // last beat, or cut by terminate or a new access
         assign burst_end[b] = (bank_st_r[b] == SDC_BURST) && (cur_bank_r == BANK_W'(b)) &&
                               (beat_r == BURST_ONE || (run && (cmd == SDC_CMD_BST || rw_cmd)));

         // one bank's row life cycle
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               bank_st_r[b] <= SDC_IDLE;
               row_r[b] <= '0;
               ap_r[b] <= 1'b0;
            end else if (run && cmd == SDC_CMD_PRE && (pin_r.addr[AP_BIT] || sel)) begin
               bank_st_r[b] <= SDC_IDLE;
               ap_r[b] <= 1'b0;
            end else if (run && cmd == SDC_CMD_ACT && sel && bank_st_r[b] == SDC_IDLE) begin
               bank_st_r[b] <= SDC_OPEN;
               row_r[b] <= pin_r.addr;
            end else if (rw_cmd && sel && bank_st_r[b] != SDC_IDLE) begin
               bank_st_r[b] <= SDC_BURST;
               ap_r[b] <= pin_r.addr[AP_BIT];
            end else if (burst_end[b]) begin
               bank_st_r[b] <= ap_r[b] ? SDC_IDLE : SDC_OPEN;
               ap_r[b] <= 1'b0;
            end
            // any other code leaves the bank as it is
         end
      end
   endgenerate

   // ************************************************************
   // burst engine and data array
   // ************************************************************
   logic [DQ_W-1:0] wr_d1_r;            // write data one clock late, beside its mask
   logic rd_beat;                       // read beat this cycle
   logic [DQ_W-1:0] rd_word;            // word leaving the array
   logic [DM_W-1:0] dqm_d1_r;           // read mask delay line
   logic [DM_W-1:0] dqm_d2_r;
   logic [DQ_W-1:0] rd_d1_r;            // read data delay line
   logic rd_d1_v_r;
   sdc_rd_s fifo_in;
   sdc_rd_s fifo_out;
   logic fifo_ready;
   logic fifo_valid;

   assign rd_beat = (beat_r != 4'h0_0) && !is_wr_r && open_vec[cur_bank_r];

   // new column each clock; new access restarts, terminate stops
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         beat_r <= '0;
         is_wr_r <= 1'b0;
         col_r <= '0;
         cur_bank_r <= '0;
      end else if (rw_cmd && open_vec[pin_r.ba]) begin
         beat_r <= BURST_LEN;
         is_wr_r <= (cmd == SDC_CMD_WR);
         col_r <= pin_r.addr[COL_W-1:0];
         cur_bank_r <= pin_r.ba;
      end else if (run && cmd == SDC_CMD_BST) begin
         beat_r <= '0;
      end else if (beat_r != 4'h0_0) begin
         beat_r <= beat_r - 1'b1;
         col_r <= col_r + 1'b1;
      end
   end

   // write beats; masked bytes left untouched
   // the first beat's data rides with the command, so data and mask are taken
   // one clock late to meet the column that the burst counter holds then
   generate
      for (genvar y = 0; y < DM_W; y++) begin : g_byte
         logic [7:0] lane [NBANK][MEM_WORDS];  // one byte lane of the array
         always_ff @(posedge ref_clk) begin
            if (beat_r != 4'h0_0 && is_wr_r && !dqm_d1_r[y] && fifo_ready) begin
               lane[cur_bank_r][col_r[MEM_AW-1:0]] <= wr_d1_r[y*8 +: 8];
            end
         end
         assign rd_word[y*8 +: 8] = lane[cur_bank_r][col_r[MEM_AW-1:0]];
      end
   endgenerate

   // read pipe: mask sampled now governs output two clocks on
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dqm_d1_r <= '1;
         dqm_d2_r <= '1;
         rd_d1_r <= '0;
         rd_d1_v_r <= 1'b0;
         wr_d1_r <= '0;
      end else begin
         wr_d1_r <= pin_r.dq;
         dqm_d1_r <= pin_r.dqm;
         dqm_d2_r <= dqm_d1_r;
         rd_d1_r <= rd_word;
         rd_d1_v_r <= rd_beat;
      end
   end

   assign fifo_in = '{oe: rd_d1_v_r ? ~dqm_d2_r : '0, data: rd_d1_r};

   // read data passes an 8-word buffer toward the pins
   sdc_fifo #(
      .WIDTH($bits(sdc_rd_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .in_valid(rd_d1_v_r),
      .in_ready(fifo_ready),
      .in_data(fifo_in),
      .out_valid(fifo_valid),
      .out_ready(1'b1),
      .out_data(fifo_out)
   );

   // ************************************************************
   // registered outputs
   // ************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dq_out <= '0;
         dq_oe <= '0;
         mode_reg <= MODE_RST;
         bank_open <= '0;
         self_refresh_on <= 1'b0;
         deepest_sleep_mode <= 1'b0;
         refresh_row <= '0;
      end else begin
         dq_out <= fifo_out.data;
         dq_oe <= fifo_valid ? fifo_out.oe : '0;
         mode_reg <= mode_r;
         bank_open <= open_vec;
         self_refresh_on <= (pwr_r == SDC_PWR_SELF);
         deepest_sleep_mode <= (pwr_r == SDC_PWR_DEEP);
         refresh_row <= rfc_r;
      end
   end
endmodule

//--- verif/sdc_core_asserts.sv
`timescale 1ns/1ps
module sdc_core_asserts
   import sdc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic cke,
   input wire logic [BANK_W-1:0] ba,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [ADDR_W-1:0] mode_reg,
   input wire logic [NBANK-1:0] bank_open,
   input wire logic self_refresh_on,
   input wire logic deepest_sleep_mode
);
   // ***
   // pin decode
   // ***
   logic [2:0] calm_r; // quiet history, so nothing is in flight
   wire logic quiet = (cs_n | (ras_n & cas_n & we_n)) & cke;
   wire logic calm = &calm_r;
   wire logic rc = ~cs_n & ~ras_n; // row strobe family
   wire logic act = rc & cas_n & we_n & cke;
   wire logic pre = rc & cas_n & ~we_n & cke;
   wire logic mld = rc & ~cas_n & ~we_n & cke;
   wire logic sref = rc & ~cas_n & we_n & ~cke;
   wire logic deep = ~cs_n & ras_n & cas_n & ~we_n & ~cke;
   // awake with every bank idle
   wire logic run = ~self_refresh_on & ~deepest_sleep_mode & (bank_open == 4'h0);
   // shift in one quiet flag per clock
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         calm_r <= 3'h0;
      end else begin
         calm_r <= {calm_r[1:0], quiet};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   // two sync flops, the state flop and the output register: effects are seen four samples on
   act_open_a: assert property (calm && act && run |-> ##4 bank_open == (4'h1 << $past(ba, 4)))
      else $error("activate did not open its bank");
   pre_all_a: assert property (pre && addr[AP_BIT] |-> ##4 bank_open == 4'h0)
      else $error("precharge all left a bank open");
   pre_one_a: assert property (pre && !addr[AP_BIT] |-> ##4 !bank_open[$past(ba, 4)])
      else $error("precharge left its bank open");
   mode_load_a: assert property (calm && mld && run |-> ##4 mode_reg == $past(addr, 4))
      else $error("mode load stored a wrong op-code");
   self_in_a: assert property (calm && sref && run |-> ##4 self_refresh_on)
      else $error("self refresh not entered");
   deep_in_a: assert property (calm && deep && run |-> ##4 deepest_sleep_mode)
      else $error("deep sleep not entered");
   sleep_hold_a: assert property ((!cke)[*4] ##0 self_refresh_on |-> ##1 self_refresh_on && $stable(mode_reg))
      else $error("self refresh disturbed by inputs");
   deep_exit_a: assert property (deepest_sleep_mode && cke |-> ##[1:5] !deepest_sleep_mode)
      else $error("deep sleep not left on enable");
endmodule

//--- verif/sdc_ctrl_model.sv
`timescale 1ns/1ps
module sdc_ctrl_model
   import sdc_pkg::*;
(
   input wire logic ref_clk,
   output sdc_pins_s pins
);
   // ***
   // controller pins
   // ***
   // deselected and awake until asked
   initial begin
      pins = '0;
      pins.cs_n = 1'b1;
      pins.cke = 1'b1;
   end
   // one command cycle, launched just after a rising edge
   task automatic cmd(input logic cs, input logic [2:0] rcw, input logic ck, input logic [BANK_W-1:0] b,
      input logic [ADDR_W-1:0] a, input logic [DM_W-1:0] m, input logic [DQ_W-1:0] d);
      @(posedge ref_clk);
      pins <= '{cs, rcw[2], rcw[1], rcw[0], ck, b, a, m, d};
   endtask
   // idle cycles: released lines never keep their last value
   task automatic nop(input int n, input logic [DM_W-1:0] m, input logic ck);
      repeat (n) begin
         @(posedge ref_clk);
         pins <= '{1'b0, 1'b1, 1'b1, 1'b1, ck, ~pins.ba, ~pins.addr, m, ~pins.dq};
      end
   endtask
   // only from all idle, then two quiet clocks
   task automatic mode_load(input logic [ADDR_W-1:0] a);
      cmd(1'b0, 3'b000, 1'b1, 2'h0, a, 2'h0, 16'h0);
      nop(2, 2'h0, 1'b1);
   endtask
   // runs are far shorter than one refresh period, so one is enough
   task automatic refresh;
      cmd(1'b0, 3'b001, 1'b1, ~pins.ba, ~pins.addr, 2'h3, ~pins.dq);
   endtask
endmodule

//--- verif/tb_sdram_command_bank_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module tb_sdram_command_bank_control
   import sdc_pkg::*;
();
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0; // hang guard
   sdc_pins_s pins;
   logic [DQ_W-1:0] dq_out;
   logic [DM_W-1:0] dq_oe;
   logic [ADDR_W-1:0] mode_reg;
   logic [NBANK-1:0] bank_open;
   logic self_refresh_on;
   logic deepest_sleep_mode;
   logic [RFC_W-1:0] refresh_row;
   logic [DQ_W-1:0] ref_mem [512]; // expected words of bank 1
   always #10 ref_clk = ~ref_clk;
   sdc_ctrl_model u_m (.ref_clk(ref_clk), .pins(pins));
   sdc_core DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
      .cas_n(pins.cas_n), .we_n(pins.we_n), .cke(pins.cke), .ba(pins.ba), .addr(pins.addr),
      .dqm(pins.dqm), .dq_in(pins.dq), .dq_out(dq_out), .dq_oe(dq_oe), .mode_reg(mode_reg),
      .bank_open(bank_open), .self_refresh_on(self_refresh_on),
      .deepest_sleep_mode(deepest_sleep_mode), .refresh_row(refresh_row));
   // ***
   // helpers
   // ***
   task automatic report_and_stop;
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // idle, then look between edges
   task automatic wait_n(input int n, input logic ck);
      u_m.nop(n, 2'h0, ck);
      @(negedge ref_clk);
   endtask
   task automatic act(input logic [1:0] b);
      u_m.cmd(1'b0, 3'b011, 1'b1, b, 12'h3c5, 2'h0, 16'h0);
      wait_n(4, 1'b1);
   endtask
   task automatic pre(input logic [1:0] b, input logic all);
      u_m.cmd(1'b0, 3'b010, 1'b1, b, {1'b0, all, 10'h0}, 2'h0, 16'h0);
      wait_n(4, 1'b1);
   endtask
   // four beats to bank 1, byte mask only on the third
   task automatic wr(input logic [COL_W-1:0] c, input logic [DM_W-1:0] m2, input logic [DQ_W-1:0] d);
      logic [DQ_W-1:0] w;
      logic [COL_W-1:0] a;
      for (int k = 0; k < 4; k++) begin
         w = d + DQ_W'(k);
         a = c + COL_W'(k);
         u_m.cmd(1'b0, (k == 0) ? 3'b100 : 3'b111, 1'b1, 2'h1, {3'h0, c}, (k == 2) ? m2 : 2'h0, w);
         ref_mem[a] = {(m2[1] && k == 2) ? ref_mem[a][15:8] : w[15:8],
            (m2[0] && k == 2) ? ref_mem[a][7:0] : w[7:0]};
      end
   endtask
   // gather driven beats; the first n0 come from c0, the rest from c1
   task automatic beats(input int n, input int n0, input logic [COL_W-1:0] c0, input logic [COL_W-1:0] c1,
      input logic [DM_W-1:0] oe, output int got);
      logic [DQ_W-1:0] m;
      logic [COL_W-1:0] c;
      m = {{8{oe[1]}}, {8{oe[0]}}};
      got = 0;
      repeat (12) begin
         @(negedge ref_clk);
         if (dq_oe !== 2'h0) begin
            c = (got < n0) ? c0 + COL_W'(got) : c1 + COL_W'(got - n0);
            if (got < n) begin
               `CHK(dq_oe, oe);
               `CHK(dq_out & m, ref_mem[c] & m);
            end
            got++;
         end
      end
   endtask
   task automatic rd(input logic [COL_W-1:0] c, input logic ap, input logic [DM_W-1:0] m);
      int got;
      u_m.cmd(1'b0, 3'b101, 1'b1, 2'h1, {1'b0, ap, 1'b0, c}, m, 16'h0);
      fork
         u_m.nop(12, m, 1'b1);
         beats(4, 4, c, c, ~m, got);
      join
      `CHK(got, 4);
   endtask
   // ***
   // scenarios
   // ***
   task automatic s_mode;
      u_m.mode_load(12'ha5c);
      wait_n(2, 1'b1);
      `CHK(mode_reg, 12'ha5c);
   endtask
   task automatic s_banks;
      act(2'h2);
      `CHK(bank_open, 4'h4);
      u_m.cmd(1'b1, 3'b011, 1'b1, 2'h0, 12'h3c5, 2'h0, 16'h0);
      wait_n(4, 1'b1);
      `CHK(bank_open, 4'h4);
      act(2'h0);
      `CHK(bank_open, 4'h5);
      pre(2'h2, 1'b0);
      `CHK(bank_open, 4'h1);
      act(2'h3);
      pre(2'h1, 1'b1);
      `CHK(bank_open, 4'h0);
   endtask
   task automatic s_data;
      int got;
      u_m.cmd(1'b0, 3'b101, 1'b1, 2'h1, 12'h000, 2'h0, 16'h0);
      fork
         u_m.nop(12, 2'h0, 1'b1);
         beats(0, 0, 9'h000, 9'h000, 2'h3, got);
      join
      `CHK(got, 0);
      act(2'h1);
      wr(9'h000, 2'h0, 16'h1000);
      wr(9'h004, 2'h0, 16'h2000);
      wr(9'h008, 2'h0, 16'h3000);
      wr(9'h008, 2'h1, 16'h4000);
      wait_n(2, 1'b1);
      rd(9'h008, 1'b0, 2'h0);
      `CHK(bank_open, 4'h2);
      rd(9'h000, 1'b0, 2'h2);
      u_m.cmd(1'b0, 3'b101, 1'b1, 2'h1, 12'h000, 2'h0, 16'h0);
      u_m.cmd(1'b0, 3'b101, 1'b1, 2'h1, 12'h004, 2'h0, 16'h0);
      fork
         u_m.nop(12, 2'h0, 1'b1);
         beats(5, 1, 9'h000, 9'h004, 2'h3, got);
      join
      `CHK(got, 5);
      u_m.cmd(1'b0, 3'b101, 1'b1, 2'h1, 12'h000, 2'h0, 16'h0);
      u_m.cmd(1'b0, 3'b110, 1'b1, 2'h1, 12'h000, 2'h0, 16'h0);
      fork
         u_m.nop(12, 2'h0, 1'b1);
         beats(4, 4, 9'h000, 9'h000, 2'h3, got);
      join
      `CHK(got < 4, 1'b1);
      rd(9'h004, 1'b1, 2'h0);
      wait_n(2, 1'b1);
      `CHK(bank_open, 4'h0);
   endtask
   task automatic s_power;
      logic [RFC_W-1:0] r;
      r = refresh_row;
      u_m.refresh();
      wait_n(4, 1'b1);
      `CHK(refresh_row, r + 1'b1);
      `CHK(bank_open, 4'h0);
      `CHK(self_refresh_on, 1'b0);
      u_m.cmd(1'b0, 3'b001, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0);
      wait_n(4, 1'b0);
      `CHK(self_refresh_on, 1'b1);
      u_m.cmd(1'b0, 3'b011, 1'b0, 2'h1, 12'h3c5, 2'h0, 16'h0);
      wait_n(4, 1'b0);
      `CHK(bank_open, 4'h0);
      wait_n(5, 1'b1);
      `CHK(self_refresh_on, 1'b0);
      u_m.cmd(1'b0, 3'b110, 1'b0, 2'h0, 12'h000, 2'h0, 16'h0);
      wait_n(4, 1'b0);
      `CHK(deepest_sleep_mode, 1'b1);
      wait_n(5, 1'b1);
      `CHK(deepest_sleep_mode, 1'b0);
   endtask
   // a stuck handshake must not hang the run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      wait_n(3, 1'b1);
      s_mode();
      s_banks();
      s_data();
      s_power();
      report_and_stop();
   end
endmodule
bind sdc_core sdc_core_asserts u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .ras_n(ras_n),
   .cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr), .mode_reg(mode_reg),
   .bank_open(bank_open), .self_refresh_on(self_refresh_on), .deepest_sleep_mode(deepest_sleep_mode));
